// ---- skb_key_builder.sv ----
// seven-tuple full key builder, layer-2 and layer-3 part of the key
// assumes the parser pulses frame_valid with all header fields valid that cycle
`timescale 1ns/100ps
`include "skb_params.svh"

module skb_key_builder (
	// clock and reset
	input logic clock,
	input logic rstn,
	// frame strobe from the parser
	input logic frame_valid,
	input logic [2:0] frame_class,
	input logic tcp_udp,
	// layer-2 header
	input logic [`SKB_MAC_W-1:0] dest_mac,
	input logic [`SKB_MAC_W-1:0] src_mac,
	input logic [`SKB_TYPE_W-1:0] type_len,
	input logic [`SKB_OCTET_W-1:0] dsap,
	input logic [`SKB_OCTET_W-1:0] ssap,
	input logic [`SKB_PID_W-1:0] snap_pid,
	// vlan
	input logic vlan_tagged,
	input logic [`SKB_VID_W-1:0] frame_vid,
	input logic [`SKB_VID_W-1:0] port_default_vid,
	// layer-3 and layer-4 header
	input logic [`SKB_OCTET_W-1:0] ip_proto,
	input logic [`SKB_TYPE_W-1:0] dest_port,
	input logic more_fragments,
	input logic [`SKB_FRAG_OFS_W-1:0] frag_offset,
	// oam
	input logic oam_masq,
	input logic [`SKB_MEL_W-1:0] oam_mel,
	// key towards the lookup match engine
	output logic key_valid,
	output logic [`SKB_KEY_W-1:0] seven_tuple_full_key,
	output logic oam_overload_flag
);

	skb_pkg::skb_frame_class_t cls;
	logic [`SKB_TYPE_W-1:0] type_overload_field;
	logic is_oam;
	logic [`SKB_KEY_W-1:0] key_build;
	logic [`SKB_KEY_W-1:0] key_ff;
	logic [`SKB_KEY_W-1:0] nxt_key_ff;
	logic key_valid_ff;
	logic nxt_key_valid_ff;
	logic oam_flag_ff;
	logic nxt_oam_flag_ff;

	assign cls = skb_pkg::skb_frame_class_t'(frame_class);

	// type field selection lives apart so the mux can be reused by other key layouts
	skb_type_mux u_type_mux (
		.frame_class(frame_class),
		.tcp_udp(tcp_udp),
		.type_len(type_len),
		.dsap(dsap),
		.ssap(ssap),
		.snap_pid(snap_pid),
		.dest_port(dest_port),
		.ip_proto(ip_proto),
		.oam_masq(oam_masq),
		.oam_mel(oam_mel),
		.type_field(type_overload_field),
		.is_oam(is_oam)
	);

	// assemble the key; bits this block does not own read as zero
	always_comb begin
		key_build = '0;
		key_build[`SKB_VID_LSB +: `SKB_VID_W] = vlan_tagged ? frame_vid : port_default_vid;
		key_build[`SKB_DMAC_LSB +: `SKB_MAC_W] = dest_mac;
		key_build[`SKB_SMAC_LSB +: `SKB_MAC_W] = src_mac;
		key_build[`SKB_TYPE_ENC_BIT] = (type_len >= `SKB_TYPE_OVERLOAD_FIELD_MIN);
		key_build[`SKB_TYPE_LSB +: `SKB_TYPE_W] = type_overload_field;
		key_build[`SKB_IP_OR_SNAP_FLAG_BIT] = (cls == skb_pkg::SKB_IPV4) ||
			(cls == skb_pkg::SKB_IPV6) || (cls == skb_pkg::SKB_SNAP);
		key_build[`SKB_IPV4_BIT] = (cls == skb_pkg::SKB_IPV4);
		// a fragment's layer-4 header may be absent, so the match engine must know
		key_build[`SKB_FRAG_BIT] = (cls == skb_pkg::SKB_IPV4) &&
			(more_fragments || (frag_offset != '0));
	end

	// key and flag hold between frames so the match engine may sample late
	always_comb begin
		nxt_key_ff = key_ff;
		nxt_oam_flag_ff = oam_flag_ff;
		nxt_key_valid_ff = frame_valid;
		if (frame_valid) begin
			nxt_key_ff = key_build;
			nxt_oam_flag_ff = is_oam;
		end
	end

	// one cycle of latency from strobe to key
	always_ff @(posedge clock) begin
		if (!rstn) begin
			key_ff <= '0;
			key_valid_ff <= 1'b0;
			oam_flag_ff <= 1'b0;
		end else begin
			key_ff <= nxt_key_ff;
			key_valid_ff <= nxt_key_valid_ff;
			oam_flag_ff <= nxt_oam_flag_ff;
		end
	end

	assign seven_tuple_full_key = key_ff;
	assign key_valid = key_valid_ff;
	assign oam_overload_flag = oam_flag_ff;

	// checks on the registered key, each one cycle after a parser strobe, a cycle without strobe, or a reset cycle
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	property p_dmac;
		frame_valid |=> key_valid && (seven_tuple_full_key[`SKB_DMAC_LSB +: `SKB_MAC_W]
			== $past(dest_mac));
	endproperty
	a_dmac: assert property (p_dmac) else $error("destination mac misplaced");

	property p_smac;
		frame_valid |=> seven_tuple_full_key[`SKB_SMAC_LSB +: `SKB_MAC_W] == $past(src_mac);
	endproperty
	a_smac: assert property (p_smac) else $error("source mac misplaced");

	property p_type_enc;
		frame_valid |=> seven_tuple_full_key[`SKB_TYPE_ENC_BIT]
			== ($past(type_len) >= `SKB_TYPE_OVERLOAD_FIELD_MIN);
	endproperty
	a_type_enc: assert property (p_type_enc) else $error("type encoded flag wrong");

	property p_llc;
		frame_valid && cls == skb_pkg::SKB_LLC |=>
			seven_tuple_full_key[`SKB_TYPE_LSB +: `SKB_TYPE_W] == {$past(dsap), $past(ssap)};
	endproperty
	a_llc: assert property (p_llc) else $error("llc type field wrong");

	property p_snap;
		frame_valid && cls == skb_pkg::SKB_SNAP |=>
			seven_tuple_full_key[`SKB_TYPE_LSB +: `SKB_TYPE_W]
			== $past(snap_pid[`SKB_PID_HI_LSB +: `SKB_TYPE_W]);
	endproperty
	a_snap: assert property (p_snap) else $error("snap type field wrong");

	property p_l4;
		frame_valid && (cls == skb_pkg::SKB_IPV4 || cls == skb_pkg::SKB_IPV6) |=>
			seven_tuple_full_key[`SKB_TYPE_LSB +: `SKB_TYPE_W] == ($past(tcp_udp) ?
			$past(dest_port) : {{`SKB_OCTET_W{1'b0}}, $past(ip_proto)});
	endproperty
	a_l4: assert property (p_l4) else $error("ip type field wrong");

	property p_type_overload_field;
		frame_valid && (cls == skb_pkg::SKB_ARP || (cls == skb_pkg::SKB_TYPE_OVERLOAD_FIELD &&
			type_len != `SKB_OAM_TYPE_OVERLOAD_FIELD)) |=>
			seven_tuple_full_key[`SKB_TYPE_LSB +: `SKB_TYPE_W] == $past(type_len);
	endproperty
	a_type_overload_field: assert property (p_type_overload_field) else $error("ethertype not passed through");

	property p_oam;
		frame_valid && cls == skb_pkg::SKB_TYPE_OVERLOAD_FIELD && type_len == `SKB_OAM_TYPE_OVERLOAD_FIELD |=>
			seven_tuple_full_key[`SKB_TYPE_LSB +: `SKB_TYPE_W]
			== {`SKB_OAM_HI, $past(oam_masq), $past(oam_mel)};
	endproperty
	a_oam: assert property (p_oam) else $error("oam encoding wrong");

	property p_oam_flag;
		frame_valid |=> oam_overload_flag == (seven_tuple_full_key[`SKB_TYPE_LSB +:
			`SKB_TYPE_W] == {`SKB_OAM_HI, $past(oam_masq), $past(oam_mel)} &&
			$past(type_len) == `SKB_OAM_TYPE_OVERLOAD_FIELD && $past(cls) == skb_pkg::SKB_TYPE_OVERLOAD_FIELD);
	endproperty
	a_oam_flag: assert property (p_oam_flag) else $error("oam indicator wrong");

	property p_ip_or_snap_flag;
		frame_valid |=> seven_tuple_full_key[`SKB_IP_OR_SNAP_FLAG_BIT] ==
			($past(cls) inside {skb_pkg::SKB_IPV4, skb_pkg::SKB_IPV6, skb_pkg::SKB_SNAP});
	endproperty
	a_ip_or_snap_flag: assert property (p_ip_or_snap_flag) else $error("ip or snap flag wrong");

	property p_ipv4;
		frame_valid |=> seven_tuple_full_key[`SKB_IPV4_BIT] == ($past(cls) == skb_pkg::SKB_IPV4);
	endproperty
	a_ipv4: assert property (p_ipv4) else $error("ipv4 flag wrong");

	property p_frag;
		frame_valid |=> seven_tuple_full_key[`SKB_FRAG_BIT] == ($past(cls) == skb_pkg::SKB_IPV4
			&& ($past(more_fragments) || $past(frag_offset) != '0));
	endproperty
	a_frag: assert property (p_frag) else $error("fragment flag wrong");

	property p_vid;
		frame_valid |=> seven_tuple_full_key[`SKB_VID_LSB +: `SKB_VID_W] ==
			($past(vlan_tagged) ? $past(frame_vid) : $past(port_default_vid));
	endproperty
	a_vid: assert property (p_vid) else $error("vid wrong");

	// an attempt that starts in a reset cycle is skipped: reset may legally clear a held key
	property p_hold;
		!frame_valid && rstn |=> !key_valid && $stable(seven_tuple_full_key) &&
			$stable(oam_overload_flag);
	endproperty
	a_hold: assert property (p_hold) else $error("key changed without a frame");

	// reset overrides any strobe, so this one ignores the default disable
	property p_reset_clear;
		disable iff (1'b0)
		!rstn |=> !key_valid && seven_tuple_full_key == '0 && !oam_overload_flag;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left outputs");

	// a valid pulse is never made up; it always follows a taken strobe
	property p_valid_src;
		key_valid |-> $past(frame_valid);
	endproperty
	a_valid_src: assert property (p_valid_src) else $error("valid without strobe");

	// invariants of the registered key: they need no strobe and hold in every cycle
	// bits owned by other builders must read zero, or a match entry could hit on them
	property p_unowned_zero;
		seven_tuple_full_key[`SKB_VID_LSB-1:0] == '0 &&
			seven_tuple_full_key[`SKB_DMAC_LSB-1:`SKB_VID_LSB+`SKB_VID_W] == '0;
	endproperty
	a_unowned_zero: assert property (p_unowned_zero) else $error("unowned bits set");

	// a fragment flag on a non-ipv4 key would describe no real frame
	property p_frag_ipv4;
		seven_tuple_full_key[`SKB_FRAG_BIT] |-> seven_tuple_full_key[`SKB_IPV4_BIT];
	endproperty
	a_frag_ipv4: assert property (p_frag_ipv4) else $error("frag without ipv4");

	// every ipv4 key is also an ip key
	property p_ipv4_ip;
		seven_tuple_full_key[`SKB_IPV4_BIT] |-> seven_tuple_full_key[`SKB_IP_OR_SNAP_FLAG_BIT];
	endproperty
	a_ipv4_ip: assert property (p_ipv4_ip) else $error("ipv4 without ip flag");

	// the indicator must always come with the fixed oam high byte; the high byte alone may also appear without it
	property p_oam_high;
		oam_overload_flag |-> seven_tuple_full_key[`SKB_TYPE_LSB+`SKB_OCTET_W +: `SKB_OCTET_W]
			== `SKB_OAM_HI;
	endproperty
	a_oam_high: assert property (p_oam_high) else $error("oam high byte missing");

	// the oam ethertype lies above the length range, so the type-encoded bit is set
	property p_oam_enc;
		oam_overload_flag |-> seven_tuple_full_key[`SKB_TYPE_ENC_BIT];
	endproperty
	a_oam_enc: assert property (p_oam_enc) else $error("oam key not type encoded");

	// per-class flags; oam is recognised on plain type-encoded frames only
	property p_oam_class;
		frame_valid && cls != skb_pkg::SKB_TYPE_OVERLOAD_FIELD |=> !oam_overload_flag;
	endproperty
	a_oam_class: assert property (p_oam_class) else $error("oam on wrong class");

	property p_ipv6_flags;
		frame_valid && cls == skb_pkg::SKB_IPV6 |=> seven_tuple_full_key[`SKB_IP_OR_SNAP_FLAG_BIT] &&
			!seven_tuple_full_key[`SKB_IPV4_BIT] && !seven_tuple_full_key[`SKB_FRAG_BIT];
	endproperty
	a_ipv6_flags: assert property (p_ipv6_flags) else $error("ipv6 flags wrong");

	property p_non_ip_flags;
		frame_valid && cls inside {skb_pkg::SKB_LLC, skb_pkg::SKB_ARP, skb_pkg::SKB_TYPE_OVERLOAD_FIELD} |=>
			!seven_tuple_full_key[`SKB_IP_OR_SNAP_FLAG_BIT] && !seven_tuple_full_key[`SKB_IPV4_BIT];
	endproperty
	a_non_ip_flags: assert property (p_non_ip_flags) else $error("non-ip flags set");

	property p_snap_flags;
		frame_valid && cls == skb_pkg::SKB_SNAP |=> seven_tuple_full_key[`SKB_IP_OR_SNAP_FLAG_BIT] &&
			!seven_tuple_full_key[`SKB_IPV4_BIT] && !seven_tuple_full_key[`SKB_FRAG_BIT];
	endproperty
	a_snap_flags: assert property (p_snap_flags) else $error("snap flags wrong");

	// codes the parser never sends fall back to the raw value and carry no class flags
	property p_unused_class;
		frame_valid && !(cls inside {skb_pkg::SKB_LLC, skb_pkg::SKB_SNAP, skb_pkg::SKB_IPV4,
			skb_pkg::SKB_IPV6, skb_pkg::SKB_ARP, skb_pkg::SKB_TYPE_OVERLOAD_FIELD}) |=>
			seven_tuple_full_key[`SKB_TYPE_LSB +: `SKB_TYPE_W] == $past(type_len) &&
			!seven_tuple_full_key[`SKB_IP_OR_SNAP_FLAG_BIT] && !oam_overload_flag;
	endproperty
	a_unused_class: assert property (p_unused_class) else $error("unused class");

	// main scenarios
	c_oam: cover property (frame_valid && cls == skb_pkg::SKB_TYPE_OVERLOAD_FIELD &&
		type_len == `SKB_OAM_TYPE_OVERLOAD_FIELD ##1 oam_overload_flag);
	c_frag: cover property (frame_valid ##1 seven_tuple_full_key[`SKB_FRAG_BIT]);
	c_snap: cover property (frame_valid && cls == skb_pkg::SKB_SNAP ##1 key_valid);
	c_b2b: cover property (frame_valid ##1 frame_valid ##1 key_valid);
	// the very first strobe after a reset release must already be taken
	c_release: cover property ($rose(rstn) ##0 frame_valid ##1 key_valid);

endmodule

// ---- skb_lookup_model.sv ----
// behavioural lookup match engine standing downstream of the key builder
// assumes key_valid is a one-cycle pulse and the key holds between pulses
`timescale 1ns/100ps
`include "skb_params.svh"

module skb_lookup_model (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// key from the builder
	input wire logic key_valid,
	input wire logic [`SKB_KEY_W-1:0] key,
	// what the engine has taken
	output logic [15:0] keys_seen_ff,
	output logic [`SKB_KEY_W-1:0] last_key_ff
);
	logic [15:0] nxt_keys_seen;
	logic [`SKB_KEY_W-1:0] nxt_last_key;

	// no back-pressure exists, so every pulse must be taken in its own cycle
	always_comb begin
		nxt_keys_seen = keys_seen_ff;
		nxt_last_key = last_key_ff;
		if (key_valid) begin
			nxt_keys_seen = keys_seen_ff + 16'h0001;
			nxt_last_key = key;
		end
	end

	// registers only; synchronous clear like the builder
	always_ff @(posedge clock) begin
		if (!rstn) begin
			keys_seen_ff <= 16'h0000;
			last_key_ff <= '0;
		end else begin
			keys_seen_ff <= nxt_keys_seen;
			last_key_ff <= nxt_last_key;
		end
	end
endmodule

// ---- skb_params.svh ----
// constants for the seven-tuple key builder: field positions, widths, codes
// assumes nothing; included by bare name from the modules
`ifndef SKB_PARAMS_SVH
`define SKB_PARAMS_SVH

// flat key vector, bit 0 up to the fragment flag
`define SKB_KEY_W 181

// common portion
`define SKB_VID_LSB 32
`define SKB_VID_W 12

// layer-2 portion
`define SKB_MAC_W 48
`define SKB_DMAC_LSB 65
`define SKB_SMAC_LSB 113
`define SKB_TYPE_ENC_BIT 161
`define SKB_TYPE_LSB 162
`define SKB_TYPE_W 16
`define SKB_IP_OR_SNAP_FLAG_BIT 178
`define SKB_IPV4_BIT 179

// layer-3 portion
`define SKB_FRAG_BIT 180
`define SKB_FRAG_OFS_W 13

// frame header codes
`define SKB_TYPE_OVERLOAD_FIELD_MIN 16'h0600
`define SKB_OAM_TYPE_OVERLOAD_FIELD 16'h8902
`define SKB_OAM_HI 8'h89
`define SKB_OCTET_W 8
`define SKB_PID_W 40
`define SKB_PID_HI_LSB 24
`define SKB_MEL_W 7

`endif

// ---- skb_pkg.sv ----
// types shared by the seven-tuple key builder and its type field mux
// assumes the frame parser has already classified each frame
package skb_pkg;

	// frame class as decoded by the upstream parser
	typedef enum logic [2:0] {
		SKB_LLC,
		SKB_SNAP,
		SKB_IPV4,
		SKB_IPV6,
		SKB_ARP,
		SKB_TYPE_OVERLOAD_FIELD
	} skb_frame_class_t;

endpackage

// ---- skb_type_mux.sv ----
// overloaded 16-bit type field selection, purely combinational
// assumes decoded header fields are stable while they are sampled
`timescale 1ns/100ps
`include "skb_params.svh"

module skb_type_mux (
	// frame classification
	input logic [2:0] frame_class,
	input logic tcp_udp,
	input logic [`SKB_TYPE_W-1:0] type_len,
	// header fields
	input logic [`SKB_OCTET_W-1:0] dsap,
	input logic [`SKB_OCTET_W-1:0] ssap,
	input logic [`SKB_PID_W-1:0] snap_pid,
	input logic [`SKB_TYPE_W-1:0] dest_port,
	input logic [`SKB_OCTET_W-1:0] ip_proto,
	input logic oam_masq,
	input logic [`SKB_MEL_W-1:0] oam_mel,
	// result
	output logic [`SKB_TYPE_W-1:0] type_field,
	output logic is_oam
);

	skb_pkg::skb_frame_class_t cls;

	assign cls = skb_pkg::skb_frame_class_t'(frame_class);

	// oam is only recognised on plain type-encoded frames, never on ip or llc
	always_comb begin
		is_oam = 1'b0;
		type_field = type_len;
		unique case (cls)
			skb_pkg::SKB_LLC: begin
				type_field = {dsap, ssap};
			end
			skb_pkg::SKB_SNAP: begin
				type_field = snap_pid[`SKB_PID_HI_LSB +: `SKB_TYPE_W];
			end
			skb_pkg::SKB_IPV4, skb_pkg::SKB_IPV6: begin
				if (tcp_udp) begin
					type_field = dest_port;
				end else begin
					type_field = {{`SKB_OCTET_W{1'b0}}, ip_proto};
				end
			end
			skb_pkg::SKB_ARP: begin
				type_field = type_len;
			end
			skb_pkg::SKB_TYPE_OVERLOAD_FIELD: begin
				if (type_len == `SKB_OAM_TYPE_OVERLOAD_FIELD) begin
					is_oam = 1'b1;
					type_field = {`SKB_OAM_HI, oam_masq, oam_mel};
				end else begin
					type_field = type_len;
				end
			end
			default: begin
				// unused class codes fall back to the raw type value
				type_field = type_len;
			end
		endcase
	end

endmodule

// ---- tb_seven_tuple_key_l2_l3_builder.sv ----
// self-checking bench for the seven-tuple key builder
// assumes one clock, synchronous active-low reset, key one cycle after strobe
`timescale 1ns/100ps
`include "skb_params.svh"

module tb_seven_tuple_key_l2_l3_builder;
	// row: class, tcp_udp, type_len, mf, offset, type field, {frag,ipv4,ipsnap,enc}, oam
	typedef struct {
		logic [2:0] cls;
		logic tu;
		logic [15:0] tl;
		logic mf;
		logic [12:0] ofs;
		logic [15:0] ty;
		logic [3:0] fl;
		logic oam;
	} skb_row_t;
	skb_row_t rows [13];
	logic clock = 1'b0, rstn = 1'b0, frame_valid = 1'b0, tcp_udp = 1'b0;
	logic [2:0] frame_class = 3'h0;
	logic [47:0] dest_mac = 48'h0, src_mac = 48'h0;
	logic [15:0] type_len = 16'h0, dest_port = 16'h1f90;
	logic [7:0] dsap = 8'h42, ssap = 8'h43, ip_proto = 8'h11;
	logic [39:0] snap_pid = 40'h0102030405;
	logic vlan_tagged = 1'b0, more_fragments = 1'b0, oam_masq = 1'b1;
	logic [11:0] frame_vid = 12'h0, port_default_vid = 12'h0f0;
	logic [12:0] frag_offset = 13'h0;
	logic [6:0] oam_mel = 7'h35;
	logic key_valid, oam_overload_flag;
	logic [`SKB_KEY_W-1:0] seven_tuple_full_key, last_key;
	logic [15:0] keys_seen;
	int err_count = 0, num_checks = 0;

	skb_key_builder DUT (.clock(clock), .rstn(rstn), .frame_valid(frame_valid),
		.frame_class(frame_class), .tcp_udp(tcp_udp), .dest_mac(dest_mac), .src_mac(src_mac),
		.type_len(type_len), .dsap(dsap), .ssap(ssap), .snap_pid(snap_pid),
		.vlan_tagged(vlan_tagged), .frame_vid(frame_vid), .port_default_vid(port_default_vid),
		.ip_proto(ip_proto), .dest_port(dest_port), .more_fragments(more_fragments),
		.frag_offset(frag_offset), .oam_masq(oam_masq), .oam_mel(oam_mel),
		.key_valid(key_valid), .seven_tuple_full_key(seven_tuple_full_key),
		.oam_overload_flag(oam_overload_flag));

	skb_lookup_model partner (.clock(clock), .rstn(rstn), .key_valid(key_valid),
		.key(seven_tuple_full_key), .keys_seen_ff(keys_seen), .last_key_ff(last_key));

	// 100 MHz clock
	initial begin
		forever #5 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string what);
		num_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	// expected key from the layout; odd rows are tagged frames
	function automatic logic [`SKB_KEY_W-1:0] ekey(input int i);
		logic [`SKB_KEY_W-1:0] k;
		k = '0;
		k[`SKB_VID_LSB +: `SKB_VID_W] = i[0] ? 12'h100 + 12'(i) : 12'h0f0;
		k[`SKB_DMAC_LSB +: `SKB_MAC_W] = 48'h0a0b0c0d0e00 + 48'(i);
		k[`SKB_SMAC_LSB +: `SKB_MAC_W] = 48'hf1f2f3f4f5f6 - 48'(i);
		k[`SKB_TYPE_ENC_BIT] = rows[i].fl[0];
		k[`SKB_TYPE_LSB +: `SKB_TYPE_W] = rows[i].ty;
		k[`SKB_IP_OR_SNAP_FLAG_BIT] = rows[i].fl[1];
		k[`SKB_IPV4_BIT] = rows[i].fl[2];
		k[`SKB_FRAG_BIT] = rows[i].fl[3];
		return k;
	endfunction

	// present row i to the builder just after an edge
	task automatic send(input int i);
		frame_valid <= 1'b1;
		frame_class <= rows[i].cls;
		tcp_udp <= rows[i].tu;
		type_len <= rows[i].tl;
		more_fragments <= rows[i].mf;
		frag_offset <= rows[i].ofs;
		vlan_tagged <= i[0];
		frame_vid <= 12'h100 + 12'(i);
		dest_mac <= 48'h0a0b0c0d0e00 + 48'(i);
		src_mac <= 48'hf1f2f3f4f5f6 - 48'(i);
	endtask

	task automatic chkrow(input int i);
		chk(key_valid === 1'b1, "key_valid missing");
		chk(seven_tuple_full_key === ekey(i), "key mismatch");
		chk(seven_tuple_full_key[177:162] === rows[i].ty, "type field");
		chk({seven_tuple_full_key[180:178], seven_tuple_full_key[161]} === rows[i].fl,
			"frame flags");
		chk(oam_overload_flag === rows[i].oam, "oam flag");
		chk(seven_tuple_full_key[43:32] === (i[0] ? 12'h100 + 12'(i) : 12'h0f0), "vid");
	endtask

	// watchdog: the whole run takes well under 100 cycles
	initial begin
		repeat (1000) @(posedge clock);
		err_count++;
		tally_and_finish();
	end

	initial begin
		rows = '{'{3'h0, 1'b0, 16'h05ff, 1'b0, 13'h0, 16'h4243, 4'h0, 1'b0},
			'{3'h1, 1'b0, 16'h05dc, 1'b0, 13'h0, 16'h0102, 4'h2, 1'b0},
			'{3'h2, 1'b1, 16'h0800, 1'b0, 13'h0, 16'h1f90, 4'h7, 1'b0},
			'{3'h2, 1'b0, 16'h0800, 1'b0, 13'h0, 16'h0011, 4'h7, 1'b0},
			'{3'h2, 1'b1, 16'h0800, 1'b1, 13'h0, 16'h1f90, 4'hf, 1'b0},
			'{3'h2, 1'b0, 16'h0800, 1'b0, 13'h1, 16'h0011, 4'hf, 1'b0},
			'{3'h3, 1'b1, 16'h86dd, 1'b1, 13'h1fff, 16'h1f90, 4'h3, 1'b0},
			'{3'h3, 1'b0, 16'h86dd, 1'b0, 13'h0, 16'h0011, 4'h3, 1'b0},
			'{3'h4, 1'b0, 16'h0806, 1'b0, 13'h0, 16'h0806, 4'h1, 1'b0},
			'{3'h5, 1'b0, 16'h0600, 1'b0, 13'h0, 16'h0600, 4'h1, 1'b0},
			'{3'h5, 1'b0, 16'h8902, 1'b0, 13'h0, 16'h89b5, 4'h1, 1'b1},
			'{3'h4, 1'b0, 16'h8902, 1'b0, 13'h0, 16'h8902, 4'h1, 1'b0},
			'{3'h7, 1'b0, 16'h88f7, 1'b0, 13'h0, 16'h88f7, 4'h1, 1'b0}};
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		#1 chk(key_valid === 1'b0 && seven_tuple_full_key === '0, "reset");
		// one frame at a time, then every row back to back
		for (int i = 0; i < 13; i++) begin
			@(posedge clock) send(i);
			@(posedge clock) frame_valid <= 1'b0;
			#1 chkrow(i);
		end
		for (int i = 0; i < 13; i++) begin
			@(posedge clock) send(i);
			if (i > 0) #1 chkrow(i - 1);
		end
		// key holds while the strobe is low, even as the inputs move
		@(posedge clock) begin
			frame_valid <= 1'b0;
			dest_mac <= 48'h0;
			type_len <= 16'h0000;
		end
		#1 chkrow(12);
		@(posedge clock);
		#1 chk(key_valid === 1'b0 && seven_tuple_full_key === ekey(12), "hold");
		chk(keys_seen === 16'h001a, "partner count");
		chk(last_key === ekey(12), "partner key");
		// reset in mid-run clears the key and the oam flag
		@(posedge clock) send(10);
		@(posedge clock) rstn <= 1'b0;
		frame_valid <= 1'b0;
		#1 chkrow(10);
		// the first strobe may come in the very cycle that reset is released
		@(posedge clock) rstn <= 1'b1;
		send(2);
		#1 chk(seven_tuple_full_key === '0 && oam_overload_flag === 1'b0, "reset");
		chk(key_valid === 1'b0 && keys_seen === 16'h0000, "partner reset");
		@(posedge clock) frame_valid <= 1'b0;
		#1 chkrow(2);
		tally_and_finish();
	end
endmodule
